/* design/gesture_defs.svh */
`ifndef GESTURE_DEFS_SVH
`define GESTURE_DEFS_SVH

// Register offsets on the serial register port.
`define THIRD_STATUS_ADDR 8'hb3
`define GST_TIME_ADDR 8'hb4
`define GESTURE_CONTROL_ADDR 8'hb5
`define SLEEP_CTRL_ADDR 8'hbc

// Field positions.
`define SLEEP_ACTIVE_BIT 1
`define GST_IRQ_EN_BIT 1
`define GST_MODE_BIT 0
`define SLEEP_CLEAR_BIT 0

// Reset values.
`define GST_TIME_RESET 8'h0a
`define GESTURE_CONTROL_RESET 8'h00
`define RDATA_RESET 8'h00

// Sample period base unit and system clock rate.
`define GST_UNIT_US 88
`define SYS_CLK_MHZ 100

// Interrupt FIFO levels for threshold codes 0 to 3.
`define FIFO_LVL_CODE0 8'h01
`define FIFO_LVL_CODE1 8'h04
`define FIFO_LVL_CODE2 8'h08
`define FIFO_LVL_CODE3 8'h10

`endif

/* design/gesture_mode_sample_control.sv */
// Operation
// - Interrupt under sleep enable stops oscillator, sets flag.
// - Sample period is 88 us times setting plus one.
// - Sample-time setting resets to 0x0A.
// - One dataset collected per elapsed sample period.
// - Gesture interrupt only while its enable is set.
// - First interrupt waits for FIFO threshold level.
// - Mode bit reads one while in gesture mode.
// - Gesture mode paces engine, pushes datasets into FIFO.
// - Writing mode one enters gesture mode immediately.
// - Writing mode zero exits after current conversion.
// - Clear bit restarts oscillator and drops sleep flag.
// - Proximity above entry threshold enters gesture mode.
// - Threshold codes select levels 1, 4, 8, 16.
`include "gesture_defs.svh"

module gesture_mode_sample_control #(
   parameter int GST_UNIT_CYCLES = `GST_UNIT_US * `SYS_CLK_MHZ
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Serial register port, byte wide
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Settings held in neighbouring registers
   input wire logic sleep_after_irq_enable,
   input wire logic gesture_engine_enable,
   input wire logic [1:0] fifo_level_threshold,
   input wire logic [15:0] entry_threshold,
   // Engine and FIFO status
   input wire logic [15:0] prox_result,
   input wire logic prox_valid,
   input wire logic exit_condition,
   input wire logic conversion_busy,
   input wire logic dataset_done,
   input wire logic [7:0] fifo_level,
   input wire logic device_irq_event,
   // Control and status outputs
   output logic osc_run,
   output logic sleep_after_irq_active,
   output logic gesture_mode_flag,
   output logic dataset_start,
   output logic fifo_push,
   output logic gesture_irq
);

   gesture_pkg::gest_state_t state_q;
   gesture_pkg::gest_state_t state_d;
   logic sleep_q;
   logic sleep_d;
   logic osc_run_q;
   logic [7:0] sample_time_q;
   logic irq_en_q;
   logic mode_q;
   logic start_q;
   logic push_q;
   logic irq_q;
   logic first_irq_done_q;
   logic [7:0] rdata_q;
   logic sample_tick;
   logic wr_status;
   logic wr_time;
   logic wr_ctrl;
   logic wr_sleep_clear;
   logic force_enter;
   logic force_exit;
   logic prox_enter;
   // Reset image of the control register, so single bits can be picked from it.
   localparam logic [7:0] CTRL_RESET_VAL = `GESTURE_CONTROL_RESET;

   // Map the two-bit threshold code to a dataset count.
   function automatic logic [7:0] fifo_level_of(input gesture_pkg::fifo_thr_code_t code);
      logic [7:0] lvl;
      lvl = `FIFO_LVL_CODE0;
      unique case (code)
         2'h0: lvl = `FIFO_LVL_CODE0;
         2'h1: lvl = `FIFO_LVL_CODE1;
         2'h2: lvl = `FIFO_LVL_CODE2;
         2'h3: lvl = `FIFO_LVL_CODE3;
      endcase
      return lvl;
   endfunction : fifo_level_of

   // Write strobes per register; reads need no strobe decode beyond the mux.
   assign wr_status = reg_wr_en && (reg_addr == `THIRD_STATUS_ADDR);
   assign wr_time = reg_wr_en && (reg_addr == `GST_TIME_ADDR);
   assign wr_ctrl = reg_wr_en && (reg_addr == `GESTURE_CONTROL_ADDR);
   assign wr_sleep_clear = reg_wr_en && (reg_addr == `SLEEP_CTRL_ADDR)
      && reg_wdata[`SLEEP_CLEAR_BIT];
   assign force_enter = wr_ctrl && reg_wdata[`GST_MODE_BIT];
   assign force_exit = wr_ctrl && !reg_wdata[`GST_MODE_BIT];
   // Entry ignores the proximity persistence filter by design.
   assign prox_enter = gesture_engine_enable && prox_valid && osc_run_q
      && (prox_result > entry_threshold);

   // Sleep flag: an interrupt under sleep enable sets it, the clear bit drops it.
   // A new interrupt in the clearing cycle wins so that event is never lost.
   always_comb begin
      sleep_d = sleep_q;
      if (wr_sleep_clear && sleep_q) begin
         sleep_d = 1'b0;
      end
      if (sleep_after_irq_enable && device_irq_event) begin
         sleep_d = 1'b1;
      end
   end

   // The status register itself is never written; only the clear bit and an interrupt under sleep enable move the flag.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= sleep_d;
      end
   end

   // Oscillator enable follows the sleep flag in the same edge.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         osc_run_q <= 1'b1;
      end else begin
         osc_run_q <= !sleep_d;
      end
   end

   // Sample-time register; the full byte is the setting.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sample_time_q <= `GST_TIME_RESET;
      end else if (wr_time) begin
         sample_time_q <= reg_wdata;
      end
   end

   // Interrupt enable; reserved control bits have no storage.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         irq_en_q <= CTRL_RESET_VAL[`GST_IRQ_EN_BIT];
      end else if (wr_ctrl) begin
         irq_en_q <= reg_wdata[`GST_IRQ_EN_BIT];
      end
   end

   // Gesture state machine. A forced exit waits in drain for the running conversion.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         gesture_pkg::GST_IDLE: begin
            if (force_enter || prox_enter) begin
               state_d = gesture_pkg::GST_ACTIVE;
            end
         end
         gesture_pkg::GST_ACTIVE: begin
            if (force_exit || exit_condition) begin
               state_d = conversion_busy ? gesture_pkg::GST_DRAIN : gesture_pkg::GST_IDLE;
            end
         end
         gesture_pkg::GST_DRAIN: begin
            if (force_enter) begin
               state_d = gesture_pkg::GST_ACTIVE;
            end else if (!conversion_busy) begin
               state_d = gesture_pkg::GST_IDLE;
            end
         end
         default: begin
            state_d = gesture_pkg::GST_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_q <= gesture_pkg::GST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Mode flag is true from the forced or detected entry until fully idle.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mode_q <= 1'b0;
      end else begin
         mode_q <= (state_d != gesture_pkg::GST_IDLE);
      end
   end

   // The period timer runs only in active gesture mode with the oscillator up.
   gesture_sample_timer #(
      .UNIT_CYCLES(GST_UNIT_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .run(osc_run_q && (state_q == gesture_pkg::GST_ACTIVE)),
      .period_sel(sample_time_q),
      .tick_q(sample_tick)
   );

   // One dataset start per elapsed period; no new start while draining.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         start_q <= 1'b0;
      end else begin
         start_q <= sample_tick && (state_q == gesture_pkg::GST_ACTIVE);
      end
   end

   // Completed datasets go to the FIFO while the mode flag is set and the oscillator runs.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         push_q <= 1'b0;
      end else begin
         push_q <= dataset_done && mode_q && osc_run_q;
      end
   end

   // The first interrupt of a gesture event waits for the threshold level.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         first_irq_done_q <= 1'b0;
      end else if (irq_q) begin
         first_irq_done_q <= 1'b1;
      end else if (!mode_q && (fifo_level == 8'h00)) begin
         first_irq_done_q <= 1'b0;
      end
   end

   // Gesture interrupt: gated by the enable, dropped as soon as the FIFO is empty.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else if (!irq_en_q || (fifo_level == 8'h00)) begin
         irq_q <= 1'b0;
      end else if (first_irq_done_q || (fifo_level >= fifo_level_of(fifo_level_threshold))) begin
         irq_q <= 1'b1;
      end
   end

   // Read data is registered and answers one cycle after the read strobe.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rdata_q <= `RDATA_RESET;
      end else if (reg_rd_en) begin
         unique case (reg_addr)
            `THIRD_STATUS_ADDR: rdata_q <= 8'(sleep_q) << `SLEEP_ACTIVE_BIT;
            `GST_TIME_ADDR: rdata_q <= sample_time_q;
            `GESTURE_CONTROL_ADDR: rdata_q <= (8'(irq_en_q) << `GST_IRQ_EN_BIT)
               | (8'(mode_q) << `GST_MODE_BIT);
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   // Output ports come straight from their flip-flops.
   assign reg_rdata = rdata_q;
   assign osc_run = osc_run_q;
   assign sleep_after_irq_active = sleep_q;
   assign gesture_mode_flag = mode_q;
   assign dataset_start = start_q;
   assign fifo_push = push_q;
   assign gesture_irq = irq_q;

   a_sleep_on_irq: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sleep_after_irq_enable && device_irq_event |=> sleep_q && !osc_run_q)
      else $error("Interrupt under sleep enable did not stop the oscillator.");

   a_sleep_clear_wakes: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sleep_q && wr_sleep_clear && !device_irq_event |=> !sleep_q && osc_run_q)
      else $error("Sleep clear did not restart the oscillator.");

   a_status_write_ro: assert property (@(posedge sys_clk) disable iff (!rst_b)
      wr_status && !wr_sleep_clear && !device_irq_event |=> $stable(sleep_q))
      else $error("Status write changed the sleep flag.");

   a_time_reset_val: assert property (@(posedge sys_clk)
      !rst_b |=> sample_time_q == `GST_TIME_RESET)
      else $error("Sample time not at its reset value.");

   a_force_entry_now: assert property (@(posedge sys_clk) disable iff (!rst_b)
      force_enter |=> mode_q && (state_q == gesture_pkg::GST_ACTIVE))
      else $error("Forced entry did not enter gesture mode.");

   a_force_exit_drain: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_q == gesture_pkg::GST_ACTIVE) && force_exit && conversion_busy
      |=> mode_q ##0 (state_q == gesture_pkg::GST_DRAIN))
      else $error("Forced exit left before the conversion ended.");

   a_drain_to_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_q == gesture_pkg::GST_DRAIN) && !conversion_busy && !force_enter |=> !mode_q)
      else $error("Mode flag still set after the conversion ended.");

   a_prox_entry: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_q == gesture_pkg::GST_IDLE) && prox_enter |=> mode_q)
      else $error("Proximity above entry threshold did not enter gesture mode.");

   a_irq_needs_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !irq_en_q |=> !irq_q)
      else $error("Gesture interrupt raised while disabled.");

   a_first_irq_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !first_irq_done_q && !irq_q && (fifo_level < fifo_level_of(fifo_level_threshold))
      |=> !irq_q)
      else $error("First gesture interrupt raised below the FIFO threshold.");

   a_push_in_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fifo_push |-> $past(mode_q) && $past(dataset_done))
      else $error("FIFO push outside gesture mode.");

   a_mode_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
      reg_rd_en && (reg_addr == `GESTURE_CONTROL_ADDR)
      |=> reg_rdata[0] == $past(mode_q) && reg_rdata[7:2] == 6'h00)
      else $error("Gesture control readback is wrong.");

endmodule : gesture_mode_sample_control

/* design/gesture_pkg.sv */
package gesture_pkg;

   // Gesture engine states, Gray coded along idle, active, drain.
   typedef enum logic [1:0] {
      GST_IDLE = 2'h0,
      GST_ACTIVE = 2'h1,
      GST_DRAIN = 2'h3
   } gest_state_t;

   // Two-bit FIFO interrupt threshold code.
   typedef logic [1:0] fifo_thr_code_t;

endpackage : gesture_pkg

/* design/gesture_sample_timer.sv */
`include "gesture_defs.svh"

module gesture_sample_timer #(
   parameter int UNIT_CYCLES = `GST_UNIT_US * `SYS_CLK_MHZ
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Control
   input wire logic run,
   input wire logic [7:0] period_sel,
   // Sample tick
   output logic tick_q
);

   logic [15:0] unit_cnt_q;
   logic [7:0] slot_cnt_q;
   logic [7:0] sel_prev_q;
   logic restart;
   logic unit_wrap;
   logic [23:0] gap_q;

   // A new period setting restarts the count so no stale partial period is kept.
   assign restart = (period_sel != sel_prev_q);
   assign unit_wrap = (unit_cnt_q == 16'(UNIT_CYCLES - 1));

   // Remember the period setting seen last cycle.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sel_prev_q <= `GST_TIME_RESET;
      end else begin
         sel_prev_q <= period_sel;
      end
   end

   // Base unit counter, one wrap per 88 us unit.
   always_ff @(posedge sys_clk) begin
      if (!rst_b || !run || restart || unit_wrap) begin
         unit_cnt_q <= 16'h0000;
      end else begin
         unit_cnt_q <= unit_cnt_q + 16'h0001;
      end
   end

   // Unit slot counter; the period is the setting plus one units.
   always_ff @(posedge sys_clk) begin
      if (!rst_b || !run || restart) begin
         slot_cnt_q <= 8'h00;
      end else if (unit_wrap) begin
         slot_cnt_q <= (slot_cnt_q == period_sel) ? 8'h00 : slot_cnt_q + 8'h01;
      end
   end

   // One-cycle tick at the end of every full sample period.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= run && !restart && unit_wrap && (slot_cnt_q == period_sel);
      end
   end

   // Cycle count since the last tick or restart, read only by the check below.
   always_ff @(posedge sys_clk) begin
      if (!rst_b || !run || restart) begin
         gap_q <= 24'h00_0000;
      end else begin
         gap_q <= tick_q ? 24'h00_0001 : gap_q + 24'h00_0001;
      end
   end

   a_tick_period_exact: assert property (@(posedge sys_clk) disable iff (!rst_b)
      tick_q |-> gap_q == 24'(UNIT_CYCLES) * (24'(period_sel) + 24'h00_0001))
      else $error("Sample tick spacing differs from the programmed period.");

endmodule : gesture_sample_timer

/* test/reg_host.sv */
// Host side of the serial register port, one byte per request.
module reg_host (
   // Clock
   input wire logic sys_clk,
   // Register port towards the device
   output logic [7:0] reg_addr,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle port before the first request.
   initial begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wdata = 8'h00;
   end

   // Strobe stands over one rising edge; released lines show the inverse, not a stale copy.
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr

   // Read data is registered, so it is taken one cycle after the strobe edge.
   task rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge sys_clk);
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      q = reg_rdata;
   endtask : rd

   // Waking from sleep takes a write of the clear bit.
   task wake();
      wr(8'hbc, 8'h01);
   endtask : wake
endmodule : reg_host

/* test/testbench.sv */
`include "gesture_defs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   // A short unit keeps the longest sample period near a thousand cycles.
   localparam int UNIT = 4;

   // Design inputs, all given a value at time zero.
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr;
   logic reg_wr_en;
   logic reg_rd_en;
   logic [7:0] reg_wdata;
   logic sleep_after_irq_enable = 1'b0;
   logic gesture_engine_enable = 1'b0;
   logic [1:0] fifo_level_threshold = 2'h0;
   logic [15:0] entry_threshold = 16'h0000;
   logic [15:0] prox_result = 16'h0000;
   logic prox_valid = 1'b0;
   logic exit_condition = 1'b0;
   logic conversion_busy = 1'b0;
   logic dataset_done = 1'b0;
   logic [7:0] fifo_level = 8'h00;
   logic device_irq_event = 1'b0;
   // Design outputs.
   logic [7:0] reg_rdata;
   logic osc_run;
   logic sleep_after_irq_active;
   logic gesture_mode_flag;
   logic dataset_start;
   logic fifo_push;
   logic gesture_irq;
   int err_count = 0;
   int n_tests = 0;

   // Free-running 100 MHz clock.
   always #5 sys_clk = ~sys_clk;

   gesture_mode_sample_control #(.GST_UNIT_CYCLES(UNIT)) DUT (
      .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sleep_after_irq_enable(sleep_after_irq_enable),
      .gesture_engine_enable(gesture_engine_enable),
      .fifo_level_threshold(fifo_level_threshold), .entry_threshold(entry_threshold),
      .prox_result(prox_result), .prox_valid(prox_valid), .exit_condition(exit_condition),
      .conversion_busy(conversion_busy), .dataset_done(dataset_done),
      .fifo_level(fifo_level), .device_irq_event(device_irq_event), .osc_run(osc_run),
      .sleep_after_irq_active(sleep_after_irq_active),
      .gesture_mode_flag(gesture_mode_flag), .dataset_start(dataset_start),
      .fifo_push(fifo_push), .gesture_irq(gesture_irq));

   reg_host hst (
      .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // Verdict and end of run.
   task finish_test();
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   // Four-state comparison, so an unknown never matches.
   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("unexpected %s: expected %0h, seen %0h", name, e, g);
         err_count++;
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc

   task rd_chk(input logic [7:0] a, input logic [7:0] e, input string name);
      logic [7:0] q;
      hst.rd(a, q);
      chk(name, e, q);
   endtask : rd_chk

   // Cycles up to the next sample pulse; a missing pulse ends the run.
   task wait_start(output int n);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (dataset_start !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         err_count++;
         finish_test();
      end
   endtask : wait_start

   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask : pulse

   function int period(input logic [7:0] t);
      return UNIT * (int'(t) + 1);
   endfunction : period

   function logic [7:0] irq_level(input logic [1:0] c);
      case (c)
         2'h0: return 8'h01;
         2'h1: return 8'h04;
         2'h2: return 8'h08;
         default: return 8'h10;
      endcase
   endfunction : irq_level

   // Main sequence.
   initial begin
      logic [7:0] w;
      logic [7:0] tsel [4];
      int n;
      void'($urandom(32'h1785));
      cyc(12);
      rst_b = 1'b1;
      cyc(1);
      chk("osc_run", 1, osc_run);
      rd_chk(`THIRD_STATUS_ADDR, 8'h00, "third_status");
      rd_chk(`GST_TIME_ADDR, `GST_TIME_RESET, "sample_time");
      rd_chk(`GESTURE_CONTROL_ADDR, 8'h00, "gesture_control");
      rd_chk(`SLEEP_CTRL_ADDR, 8'h00, "sleep_ctrl");
      rd_chk(8'h42, 8'h00, "unmapped");
      hst.wr(`GESTURE_CONTROL_ADDR, 8'hfe);
      rd_chk(`GESTURE_CONTROL_ADDR, 8'h02, "ctrl_reserved");
      w = 8'($urandom);
      hst.wr(`GST_TIME_ADDR, w);
      rd_chk(`GST_TIME_ADDR, w, "sample_time_rw");
      hst.wr(`GESTURE_CONTROL_ADDR, 8'h00);
      hst.wr(`GESTURE_CONTROL_ADDR, 8'h01);
      chk("mode_enter", 1, gesture_mode_flag);
      rd_chk(`GESTURE_CONTROL_ADDR, 8'h01, "mode_read");
      // Settings assumed long enough for the pulse count in use.
      tsel = '{8'h00, 8'h0a, 8'h01 + 8'($urandom_range(14)), 8'hff};
      foreach (tsel[i]) begin
         hst.wr(`GST_TIME_ADDR, tsel[i]);
         wait_start(n);
         wait_start(n);
         chk("period", period(tsel[i]), n);
      end
      dataset_done = 1'b1;
      cyc(1);
      chk("push", 1, fifo_push);
      dataset_done = 1'b0;
      conversion_busy = 1'b1;
      hst.wr(`GESTURE_CONTROL_ADDR, 8'h00);
      cyc(3);
      chk("drain_mode", 1, gesture_mode_flag);
      // Writing one while draining resumes sampling with a fresh period count.
      hst.wr(`GESTURE_CONTROL_ADDR, 8'h01);
      wait_start(n);
      chk("reenter_first", period(8'hff) + 1, n);
      hst.wr(`GESTURE_CONTROL_ADDR, 8'h00);
      cyc(3);
      chk("drain_again", 1, gesture_mode_flag);
      conversion_busy = 1'b0;
      cyc(2);
      chk("drain_exit", 0, gesture_mode_flag);
      // The push pulse would stand for one cycle only, so look right after the edge.
      dataset_done = 1'b1;
      cyc(1);
      chk("push_idle", 0, fifo_push);
      dataset_done = 1'b0;
      entry_threshold = 16'($urandom_range(16'hfff0));
      gesture_engine_enable = 1'b1;
      prox_result = entry_threshold;
      pulse(prox_valid);
      chk("equal_no_entry", 0, gesture_mode_flag);
      prox_result = entry_threshold + 16'h0001;
      pulse(prox_valid);
      chk("prox_entry", 1, gesture_mode_flag);
      pulse(exit_condition);
      chk("exit_cond", 0, gesture_mode_flag);
      gesture_engine_enable = 1'b0;
      // Interrupt level per threshold code, first-done latch cleared by an empty FIFO.
      hst.wr(`GESTURE_CONTROL_ADDR, 8'h02);
      for (int c = 0; c < 4; c++) begin
         fifo_level_threshold = 2'(c);
         fifo_level = 8'h00;
         cyc(2);
         fifo_level = irq_level(2'(c)) - 8'h01;
         cyc(2);
         chk("irq_below", 0, gesture_irq);
         fifo_level = irq_level(2'(c));
         cyc(2);
         chk("irq_at", 1, gesture_irq);
      end
      // After the first interrupt any non-empty level keeps it raised.
      fifo_level = 8'h01;
      cyc(2);
      chk("irq_after_first", 1, gesture_irq);
      hst.wr(`GESTURE_CONTROL_ADDR, 8'h00);
      cyc(1);
      chk("irq_disabled", 0, gesture_irq);
      fifo_level = 8'h00;
      // Sleep only when enabled, flag read-only, cleared by the wake write.
      pulse(device_irq_event);
      chk("no_sleep", 1, osc_run);
      sleep_after_irq_enable = 1'b1;
      device_irq_event = 1'b1;
      cyc(1);
      device_irq_event = 1'b0;
      chk("osc_stop", 0, osc_run);
      chk("sleep_flag", 1, sleep_after_irq_active);
      hst.wr(`THIRD_STATUS_ADDR, 8'hff);
      rd_chk(`THIRD_STATUS_ADDR, 8'h02, "status_sleep");
      // An interrupt in the clearing cycle keeps the device asleep.
      fork
         hst.wake();
         begin
            @(negedge sys_clk);
            device_irq_event = 1'b1;
            @(negedge sys_clk);
            device_irq_event = 1'b0;
         end
      join
      chk("sleep_set_wins", 1, sleep_after_irq_active);
      chk("osc_still_off", 0, osc_run);
      hst.wake();
      chk("osc_resume", 1, osc_run);
      chk("sleep_clear", 0, sleep_after_irq_active);
      rd_chk(`THIRD_STATUS_ADDR, 8'h00, "status_awake");
      finish_test();
   end
endmodule : testbench
